// file: rtl/usb_list_frame_pkg.sv
// Constants for the list-pointer and frame-timing register slice
// ****************************************************************
// ****************************************************************
package usb_list_frame_pkg;

  // ****************************************************************
  // Register offsets (byte addresses as printed)
  // ****************************************************************
  localparam logic [7:0] OFS_OWNER_EN = 8'h12;
  localparam logic [7:0] OFS_IRQ_DIS = 8'h14;
  localparam logic [7:0] OFS_OWNER_DIS = 8'h16;
  localparam logic [7:0] OFS_COMM_AREA = 8'h18;
  localparam logic [7:0] OFS_PERIODIC_CUR = 8'h1c;
  localparam logic [7:0] OFS_CTRL_HEAD = 8'h20;
  localparam logic [7:0] OFS_CTRL_CUR = 8'h24;
  localparam logic [7:0] OFS_BULK_HEAD = 8'h28;
  localparam logic [7:0] OFS_BULK_CUR = 8'h2c;
  localparam logic [7:0] OFS_DONE_HEAD = 8'h30;
  localparam logic [7:0] OFS_FRAME_LEN = 8'h34;
  localparam logic [7:0] OFS_FRAME_CNT = 8'h38;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MASTER_BIT = 15;
  localparam int OWNER_CHG_BIT = 14;
  localparam int TOGGLE_BIT = 31;
  localparam int FATAL_BIT = 4;
  localparam int SRC_W = 7;
  localparam int COMM_LSB = 8;
  localparam int PTR_LSB = 4;
  localparam int FRAME_W = 14;
  localparam int FNUM_W = 16;
  localparam logic [SRC_W-1:0] SRC_MASK = 7'h6f;

  // List pointer slots
  localparam int NUM_PTR = 6;
  localparam int PTR_PERIODIC_CUR = 0;
  localparam int PTR_CTRL_HEAD = 1;
  localparam int PTR_CTRL_CUR = 2;
  localparam int PTR_BULK_HEAD = 3;
  localparam int PTR_BULK_CUR = 4;
  localparam int PTR_DONE_HEAD = 5;
  localparam logic [NUM_PTR-1:0] PTR_SW_WRITABLE = 6'h07;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [FRAME_W-1:0] FRAME_LEN_RST = 14'h00bb;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

endpackage

// file: rtl/usb_host_list_frame_regs.sv
// Host controller list pointers, ownership enables and frame timer
`timescale 1ns/1ps
module usb_host_list_frame_regs #(
  parameter int FRAME_BITS = usb_list_frame_pkg::FRAME_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Primary interrupt enable and status, held outside this slice
  input wire logic [usb_list_frame_pkg::SRC_W-1:0] src_enable,
  input wire logic [usb_list_frame_pkg::SRC_W-1:0] src_status,
  input wire logic owner_change_status,
  output logic [usb_list_frame_pkg::SRC_W-1:0] src_disable_pulse,
  output logic irq,
  // List processor pointer updates
  input wire logic [usb_list_frame_pkg::NUM_PTR-1:0] ptr_load,
  input wire logic [27:0] ptr_value,
  // Frame timing
  input wire logic operational_state,
  input wire logic bit_tick,
  output logic frame_end,
  output logic frame_wrap,
  output logic [usb_list_frame_pkg::FNUM_W-1:0] frame_number,
  output logic [FRAME_BITS-1:0] frame_remaining,
  output logic [31:0] comm_area_ptr
);
  import usb_list_frame_pkg::*;

  // Counter and read path are sized for the fixed 14-bit frame field
  if (FRAME_BITS != FRAME_W) begin : g_bad_frame_bits
    $error("FRAME_BITS must equal the 14-bit frame field");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_owner_en, wr_irq_dis, wr_owner_dis, wr_comm, wr_len, wr_cnt;
  assign wr_owner_en = reg_wr && (reg_addr == OFS_OWNER_EN);
  assign wr_irq_dis = reg_wr && (reg_addr == OFS_IRQ_DIS);
  assign wr_owner_dis = reg_wr && (reg_addr == OFS_OWNER_DIS);
  assign wr_comm = reg_wr && (reg_addr == OFS_COMM_AREA);
  assign wr_len = reg_wr && (reg_addr == OFS_FRAME_LEN);
  assign wr_cnt = reg_wr && (reg_addr == OFS_FRAME_CNT);

  // ****************************************************************
  // Ownership enables
  // ****************************************************************
  logic master_irq_on_r, owner_change_irq_on_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_irq_on_r <= 1'b0;
      owner_change_irq_on_r <= 1'b0;
    end else if (wr_owner_en) begin
      master_irq_on_r <= reg_wdata[MASTER_BIT];
      owner_change_irq_on_r <= reg_wdata[OWNER_CHG_BIT];
    end else if (wr_owner_dis) begin
      // Write 0 leaves the enable untouched
      if (reg_wdata[MASTER_BIT]) begin
        master_irq_on_r <= 1'b0;
      end
      if (reg_wdata[OWNER_CHG_BIT]) begin
        owner_change_irq_on_r <= 1'b0;
      end
    end
  end

  // Source disables become one-cycle clear pulses to the enable owner
  always_comb begin
    src_disable_pulse = wr_irq_dis ? (reg_wdata[SRC_W-1:0] & SRC_MASK) : '0;
  end

  // Registered so the pin never glitches on decode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= master_irq_on_r &&
             (|(src_status & src_enable & SRC_MASK) ||
              (owner_change_status && owner_change_irq_on_r));
    end
  end

  // ****************************************************************
  // Communication area and list pointers
  // ****************************************************************
  logic [31-COMM_LSB:0] comm_area_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_area_r <= '0;
    end else if (wr_comm) begin
      comm_area_r <= reg_wdata[31:COMM_LSB];
    end
  end
  assign comm_area_ptr = {comm_area_r, {COMM_LSB{1'b0}}};

  logic [27:0] ptr_r [NUM_PTR];
  logic [7:0] ptr_ofs [NUM_PTR];
  assign ptr_ofs[PTR_PERIODIC_CUR] = OFS_PERIODIC_CUR;
  assign ptr_ofs[PTR_CTRL_HEAD] = OFS_CTRL_HEAD;
  assign ptr_ofs[PTR_CTRL_CUR] = OFS_CTRL_CUR;
  assign ptr_ofs[PTR_BULK_HEAD] = OFS_BULK_HEAD;
  assign ptr_ofs[PTR_BULK_CUR] = OFS_BULK_CUR;
  assign ptr_ofs[PTR_DONE_HEAD] = OFS_DONE_HEAD;

  // Hardware load wins over a software write in the same cycle
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ptr_r[i] <= '0;
      end else if (ptr_load[i]) begin
        ptr_r[i] <= ptr_value;
      end else if (reg_wr && (reg_addr == ptr_ofs[i]) && PTR_SW_WRITABLE[i]) begin
        ptr_r[i] <= reg_wdata[31:PTR_LSB];
      end
    end
  end

  // ****************************************************************
  // Frame interval, remaining counter and frame number
  // ****************************************************************
  logic [FRAME_W-1:0] frame_len_r;
  logic len_toggle_r, cnt_toggle_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_len_r <= FRAME_LEN_RST;
      len_toggle_r <= 1'b0;
    end else if (wr_len) begin
      frame_len_r <= reg_wdata[FRAME_W-1:0];
      len_toggle_r <= reg_wdata[TOGGLE_BIT];
    end
  end

  logic oper_d_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oper_d_r <= 1'b0;
    end else begin
      oper_d_r <= operational_state;
    end
  end

  logic enter_oper, reload;
  assign enter_oper = operational_state && !oper_d_r;
  assign reload = operational_state && bit_tick && (frame_remaining == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_remaining <= '0;
      cnt_toggle_r <= 1'b0;
    end else begin
      if (wr_cnt) begin
        cnt_toggle_r <= reg_wdata[TOGGLE_BIT];
      end
      if (enter_oper) begin
        frame_remaining <= frame_len_r;
      end else if (reload) begin
        frame_remaining <= frame_len_r;
      end else if (wr_cnt) begin
        frame_remaining <= reg_wdata[FRAME_W-1:0];
      end else if (operational_state && bit_tick) begin
        frame_remaining <= frame_remaining - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_number <= '0;
      frame_end <= 1'b0;
      frame_wrap <= 1'b0;
    end else begin
      frame_end <= reload;
      frame_wrap <= 1'b0;
      if (reload) begin
        frame_number <= frame_number + 1'b1;
        // Bit 15 flips on 7fff->8000 and on ffff->0000
        frame_wrap <= &frame_number[FNUM_W-2:0];
      end
    end
  end

  // ****************************************************************
  // Read path; unmapped offsets read zero
  // ****************************************************************
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    case (reg_addr)
      OFS_OWNER_EN, OFS_OWNER_DIS: begin
        rd_nxt[MASTER_BIT] = master_irq_on_r;
        rd_nxt[OWNER_CHG_BIT] = owner_change_irq_on_r;
      end
      OFS_IRQ_DIS: rd_nxt[SRC_W-1:0] = src_enable & SRC_MASK;
      OFS_COMM_AREA: rd_nxt = comm_area_ptr;
      OFS_PERIODIC_CUR: rd_nxt = {ptr_r[PTR_PERIODIC_CUR], 4'h0};
      OFS_CTRL_HEAD: rd_nxt = {ptr_r[PTR_CTRL_HEAD], 4'h0};
      OFS_CTRL_CUR: rd_nxt = {ptr_r[PTR_CTRL_CUR], 4'h0};
      OFS_BULK_HEAD: rd_nxt = {ptr_r[PTR_BULK_HEAD], 4'h0};
      OFS_BULK_CUR: rd_nxt = {ptr_r[PTR_BULK_CUR], 4'h0};
      OFS_DONE_HEAD: rd_nxt = {ptr_r[PTR_DONE_HEAD], 4'h0};
      OFS_FRAME_LEN: begin
        rd_nxt[TOGGLE_BIT] = len_toggle_r;
        rd_nxt[FRAME_W-1:0] = frame_len_r;
      end
      OFS_FRAME_CNT: begin
        rd_nxt[TOGGLE_BIT] = cnt_toggle_r;
        rd_nxt[FRAME_W-1:0] = frame_remaining;
      end
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule // usb_host_list_frame_regs

// file: tb/usb_host_list_frame_props.sv
// Concurrent checks for the list pointer and frame timer slice
`timescale 1ns/1ps
module usb_host_list_frame_props #(
  parameter int FRAME_BITS = 14
) (
  // Watched ports
  input wire logic clk, rst_n, reg_wr, reg_rd, irq, owner_change_status,
  input wire logic operational_state, bit_tick, frame_end, frame_wrap,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata, comm_area_ptr,
  input wire logic [6:0] src_enable, src_status, src_disable_pulse,
  input wire logic [15:0] frame_number,
  input wire logic [FRAME_BITS-1:0] frame_remaining
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic cnt_wr;
  assign cnt_wr = reg_wr && reg_addr == 8'h38;
  // Shadow of software-visible state, built from bus writes only
  logic [13:0] len_seen;
  logic master_seen;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_seen <= 14'h00bb;
      master_seen <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h34) begin
        len_seen <= reg_wdata[13:0];
      end
      if (reg_wr && reg_addr == 8'h12) begin
        master_seen <= reg_wdata[15];
      end else if (reg_wr && reg_addr == 8'h16 && reg_wdata[15]) begin
        master_seen <= 1'b0;
      end
    end
  end
  // Entry edge excluded: the load wins there
  sequence tick_s;
    operational_state && $past(operational_state) && bit_tick && !cnt_wr;
  endsequence
  sequence reload_s;
    tick_s ##0 frame_remaining == 0;
  endsequence
  AST_DIS_PULSE: assert property (
    src_disable_pulse == ((reg_wr && reg_addr == 8'h14) ? (reg_wdata[6:0] & 7'h6f) : 7'h00))
    else $error("Disable pulse wrong");
  AST_NO_FATAL: assert property (!src_disable_pulse[4])
    else $error("Fatal disable bit set");
  AST_COMM: assert property (
    reg_wr && reg_addr == 8'h18 |=> comm_area_ptr == {$past(reg_wdata[31:8]), 8'h00})
    else $error("Comm area pointer wrong");
  AST_COUNT: assert property (
    tick_s ##0 frame_remaining != 0 |=> frame_remaining == $past(frame_remaining) - 1'b1)
    else $error("Countdown step wrong");
  AST_IDLE: assert property (!operational_state && !cnt_wr |=> $stable(frame_remaining))
    else $error("Counted while idle");
  AST_RELOAD: assert property (
    reload_s |=> frame_number == $past(frame_number) + 1'b1 ##[0:1] frame_end)
    else $error("Reload without frame advance");
  AST_WRAP: assert property ($changed(frame_number[15]) |-> ##[0:1] frame_wrap)
    else $error("Missing wrap event");
  AST_IRQ: assert property (irq |-> $past((|(src_status & src_enable)) || owner_change_status))
    else $error("Interrupt without cause");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved");
  AST_ENTRY: assert property (
    operational_state && !$past(operational_state) |=> frame_remaining == $past(len_seen))
    else $error("Entry load wrong");
  AST_RELOAD_VAL: assert property (reload_s |=> frame_remaining == $past(len_seen))
    else $error("Reload value wrong");
  AST_IRQ_GATE: assert property (!master_seen |=> !irq)
    else $error("Interrupt with master off");
endmodule // usb_host_list_frame_props
bind usb_host_list_frame_regs usb_host_list_frame_props #(.FRAME_BITS(FRAME_BITS)) u_props (
  .clk, .rst_n, .reg_wr, .reg_rd, .irq, .owner_change_status, .operational_state, .bit_tick,
  .frame_end, .frame_wrap, .reg_addr, .reg_wdata, .reg_rdata, .comm_area_ptr, .src_enable,
  .src_status, .src_disable_pulse, .frame_number, .frame_remaining);

// file: tb/testbench.sv
// Self-checking bench for the list pointer and frame timer slice
`timescale 1ns/1ps
module testbench;
  import usb_list_frame_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, owner_change_status = 0, rd_d = 0;
  logic operational_state = 0, bit_tick = 0, tick_all = 0, irq, frame_end, frame_wrap;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, comm_area_ptr;
  logic [31:0] seed = 32'h2ddb_c102, tseed = 32'h2ddb_c102, mem [NUM_PTR], exq [$];
  logic [6:0] src_enable = 7'h00, src_status = 7'h01, src_disable_pulse;
  logic [5:0] ptr_load = 6'h00;
  logic [27:0] ptr_value = 28'h000_0000;
  logic [15:0] frame_number;
  logic [13:0] frame_remaining;
  int fails = 0, n_compared = 0, i;
  always #50 clk = ~clk;
  usb_host_list_frame_regs #(.FRAME_BITS(14)) dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .src_enable, .src_status, .owner_change_status, .src_disable_pulse,
    .irq, .ptr_load, .ptr_value, .operational_state, .bit_tick, .frame_end, .frame_wrap,
    .frame_number, .frame_remaining, .comm_area_ptr);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait; a pulse is caught on the edge after it rises
  task automatic await(ref logic sig, input int lim);
    for (int k = 0; k < lim && sig !== 1'b1; k++) @(posedge clk);
    check(sig, 1'b1);
    if (sig !== 1'b1) wrap_up();
  endtask
  // Read data lands one edge after the strobe
  always @(posedge clk) begin
    if (rd_d) check(reg_rdata, exq.pop_front());
    rd_d <= reg_rd;
  end
  // Random bit ticks also hit the idle state, where nothing may count
  always @(posedge clk) begin
    tseed = xs(tseed);
    bit_tick <= tick_all | tseed[0];
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    seed = xs(seed);
    src_enable <= seed[6:0] | 7'h01;
    for (i = 8'h18; i <= 8'h40; i += 4) rd(i[7:0], (i == 8'h34) ? 32'h0000_00bb : 32'h0);
    rd(OFS_IRQ_DIS, {25'h0, src_enable & SRC_MASK});
    rd(OFS_OWNER_EN, 32'h0000_0000);
    check(irq, 1'b0);
    wr(OFS_OWNER_EN, 32'h0000_c000);
    rd(OFS_OWNER_DIS, 32'h0000_c000);
    check(irq, 1'b1);
    wr(OFS_OWNER_DIS, 32'h0000_8000);
    rd(OFS_OWNER_EN, 32'h0000_4000);
    check(irq, 1'b0);
    wr(OFS_OWNER_DIS, 32'h0000_4000);
    rd(OFS_OWNER_EN, 32'h0000_0000);
    wr(OFS_IRQ_DIS, 32'h0000_007f);
    for (i = 0; i < NUM_PTR; i++) begin
      seed = xs(seed);
      mem[i] = {seed[31:4], 4'h0};
      @(posedge clk);
      ptr_load <= 6'h01 << i;
      ptr_value <= seed[31:4];
      @(posedge clk);
      ptr_load <= 6'h00;
      rd(OFS_PERIODIC_CUR + 8'(4 * i), mem[i]);
      seed = xs(seed);
      wr(OFS_PERIODIC_CUR + 8'(4 * i), seed);
      if (PTR_SW_WRITABLE[i]) mem[i] = {seed[31:4], 4'h0};
      rd(OFS_PERIODIC_CUR + 8'(4 * i), mem[i]);
    end
    seed = xs(seed);
    wr(OFS_COMM_AREA, seed);
    rd(OFS_COMM_AREA, {seed[31:8], 8'h00});
    wr(OFS_FRAME_CNT, 32'h8000_0007);
    rd(OFS_FRAME_CNT, 32'h8000_0007);
    wr(OFS_FRAME_LEN, 32'h8000_0005);
    rd(OFS_FRAME_LEN, 32'h8000_0005);
    @(posedge clk);
    operational_state <= 1'b1;
    repeat (2) @(posedge clk);
    check(frame_remaining, 14'h0005);
    await(frame_end, 60);
    check(frame_number, 16'h0001);
    tick_all <= 1'b1;
    wr(OFS_FRAME_LEN, 32'h0000_0000);
    await(frame_wrap, 40000);
    check(frame_number[15], 1'b1);
    wrap_up();
  end
endmodule // testbench
